// >>> core/tqf_pkg.sv
// Constants for the queue flag and mailbox bypass block
package tqf_pkg;
  localparam int DEPTH       = 256;
  localparam int AW          = 8;
  localparam int QW          = 36;
  localparam int MW          = 18;
  localparam int OFS_W       = 10;
  localparam logic [OFS_W-1:0] OFS_PRESET = 10'h008;
  localparam int SYNC_STAGES = 2;
  localparam int FIFO_DEPTH  = 16;
  localparam int FIFO_WIDTH  = 36;
endpackage

// >>> core/tqf_fifo.sv
// Small valid/ready FIFO used on the port C input path
`timescale 1ns/1ns
module tqf_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0]      wp;
  logic [PW:0]      rp;
  logic             do_wr;
  logic             do_rd;

  assign in_ready  = (wp - rp) != (PW+1)'(DEPTH);
  assign out_valid = wp != rp;
  assign out_data  = mem[rp[PW-1:0]];
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;

  always_ff @(posedge sys_clk) begin
    if (do_wr) begin
      mem[wp[PW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wp <= '0;
      rp <= '0;
    end else begin
      if (do_wr) begin
        wp <= wp + 1'b1;
      end
      if (do_rd) begin
        rp <= rp + 1'b1;
      end
    end
  end
endmodule

// >>> core/tqf_core.sv
// Queue status flags and mailbox bypass registers for two queues
`timescale 1ns/1ns
module tqf_core
  import tqf_pkg::*;
#(
  parameter int DEPTH_P = tqf_pkg::DEPTH
) (
  // System clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      rst_n,
  // Mode and offsets
  input  wire logic                      fall_through_mode,
  input  wire logic                      port_b_byte_size,
  input  wire logic                      port_c_byte_size,
  input  wire logic                      offset_load,
  input  wire logic [tqf_pkg::OFS_W-1:0] ab_empty_offset_in,
  input  wire logic [tqf_pkg::OFS_W-1:0] ab_full_offset_in,
  input  wire logic [tqf_pkg::OFS_W-1:0] ca_empty_offset_in,
  input  wire logic [tqf_pkg::OFS_W-1:0] ca_full_offset_in,
  // Port A
  input  wire logic                      port_a_clock,
  input  wire logic                      port_a_select_n,
  input  wire logic                      port_a_write_not_read,
  input  wire logic                      port_a_enable,
  input  wire logic                      port_a_mail_select,
  input  wire logic [tqf_pkg::QW-1:0]    port_a_data_in,
  output logic      [tqf_pkg::QW-1:0]    port_a_data_out,
  output logic                           port_a_data_oe_n,
  output logic                           port_a_full_or_in_ready,
  output logic                           port_a_empty_or_out_ready,
  output logic                           port_a_almost_empty,
  output logic                           port_a_almost_full,
  output logic                           ca_mail_flag,
  // Port B
  input  wire logic                      port_b_clock,
  input  wire logic                      port_b_select_n,
  input  wire logic                      port_b_read_enable,
  input  wire logic                      port_b_mail_select,
  output logic      [tqf_pkg::MW-1:0]    port_b_data_out,
  output logic                           port_b_data_oe_n,
  output logic                           port_b_empty_or_out_ready,
  output logic                           port_b_almost_empty,
  output logic                           ab_mail_flag,
  // Port C
  input  wire logic                      port_c_clock,
  input  wire logic                      port_c_write_enable,
  input  wire logic                      port_c_mail_select,
  input  wire logic [tqf_pkg::MW-1:0]    port_c_data_in,
  output logic                           port_c_full_or_in_ready,
  output logic                           port_c_almost_full
);
  import tqf_pkg::*;

  localparam int PW = $clog2(DEPTH_P);
  localparam int NS = 3 + 2*SYNC_STAGES + 1;

  // Synchronise port pins: index 0..2 clocks, then controls
  logic [NS-1:0] raw;
  logic [NS-1:0] s1;
  logic [NS-1:0] s2;
  logic [2:0]    clk_d;
  assign raw = {port_c_mail_select, port_c_write_enable, port_b_mail_select,
                port_b_read_enable, port_b_select_n, port_c_clock, port_b_clock,
                port_a_clock};

  genvar g;
  generate
    for (g = 0; g < NS; g++) begin : g_sync
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          s1[g] <= (g == 3);
          s2[g] <= (g == 3);
        end else begin
          s1[g] <= raw[g];
          s2[g] <= s1[g];
        end
      end
    end
  endgenerate

  // Port A controls and data are sampled through two stages as well
  logic [QW+3:0] a_s1;
  logic [QW+3:0] a_s2;
  logic [MW-1:0] c_s1;
  logic [MW-1:0] c_s2;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      a_s1  <= {1'b1, (QW+3)'(0)};
      a_s2  <= {1'b1, (QW+3)'(0)};
      c_s1  <= '0;
      c_s2  <= '0;
      clk_d <= '0;
    end else begin
      a_s1  <= {port_a_select_n, port_a_write_not_read, port_a_enable,
                port_a_mail_select, port_a_data_in};
      a_s2  <= a_s1;
      c_s1  <= port_c_data_in;
      c_s2  <= c_s1;
      clk_d <= s2[2:0];
    end
  end

  // Rising edges of each port clock, seen in the system clock
  logic edge_a;
  logic edge_b;
  logic edge_c;
  assign edge_a = s2[0] && !clk_d[0];
  assign edge_b = s2[1] && !clk_d[1];
  assign edge_c = s2[2] && !clk_d[2];

  logic a_sel;
  logic a_mb;
  logic a_wr;
  logic a_rd;
  assign a_sel = !a_s2[QW+3] && a_s2[QW+1];
  assign a_mb  = a_s2[QW];
  assign a_wr  = edge_a && a_sel && a_s2[QW+2];
  assign a_rd  = edge_a && a_sel && !a_s2[QW+2];

  logic b_rd;
  logic c_wr;
  assign b_rd = edge_b && !s2[3] && s2[4];
  assign c_wr = edge_c && s2[6];

  // Offsets: preset at reset, loaded in parallel afterwards
  logic [OFS_W-1:0] ab_empty_offset;
  logic [OFS_W-1:0] ab_full_offset;
  logic [OFS_W-1:0] ca_empty_offset;
  logic [OFS_W-1:0] ca_full_offset;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ab_empty_offset <= OFS_PRESET;
      ab_full_offset  <= OFS_PRESET;
      ca_empty_offset <= OFS_PRESET;
      ca_full_offset  <= OFS_PRESET;
    end else if (offset_load) begin
      ab_empty_offset <= ab_empty_offset_in;
      ab_full_offset  <= ab_full_offset_in;
      ca_empty_offset <= ca_empty_offset_in;
      ca_full_offset  <= ca_full_offset_in;
    end
  end

  // Port C packs 18-bit halves into 36-bit words via the FIFO
  logic          c_half;
  logic [MW-1:0] c_hold;
  logic          cf_valid;
  logic [QW-1:0] cf_data;
  logic          cf_ready;
  logic          cq_valid;
  logic [QW-1:0] cq_data;
  logic          cq_take;

  // A-to-B queue
  logic [QW-1:0] ab_mem [DEPTH_P];
  logic [PW:0]   ab_wp;
  logic [PW:0]   ab_rp;
  logic [PW:0]   ab_cnt;
  logic          ab_out_full;
  logic [QW-1:0] ab_out;
  logic          ab_wr_ok;
  logic          ab_rd_ok;
  logic          ab_ld;

  // C-to-A queue
  logic [QW-1:0] ca_mem [DEPTH_P];
  logic [PW:0]   ca_wp;
  logic [PW:0]   ca_rp;
  logic [PW:0]   ca_cnt;
  logic          ca_out_full;
  logic [QW-1:0] ca_out;
  logic          ca_wr_ok;
  logic          ca_rd_ok;
  logic          ca_ld;

  assign ab_cnt = ab_wp - ab_rp;
  assign ca_cnt = ca_wp - ca_rp;

  // Flag views in each reader or writer domain
  logic          ab_full_n;
  logic          ca_full_n;
  logic          ab_avail;
  logic          ca_avail;
  logic [1:0]    ab_fdly;
  logic [1:0]    ca_fdly;
  logic [2:0]    ab_edly;
  logic [2:0]    ca_edly;

  assign ab_full_n = ab_cnt != (PW+1)'(DEPTH_P);
  assign ca_full_n = ca_cnt != (PW+1)'(DEPTH_P);
  assign ab_avail  = ab_cnt != '0;
  assign ca_avail  = ca_cnt != '0;

  assign ab_wr_ok = a_wr && !a_mb && port_a_full_or_in_ready;
  assign ca_wr_ok = cq_valid && port_c_full_or_in_ready;
  assign cq_take  = ca_wr_ok;

  // Read acceptance: standard reads from memory; fall-through reloads
  assign ab_rd_ok = b_rd && !s2[5] && port_b_empty_or_out_ready;
  assign ca_rd_ok = a_rd && !a_mb && port_a_empty_or_out_ready;
  assign ab_ld = fall_through_mode ? (ab_edly[2] && (!ab_out_full || ab_rd_ok))
                                   : ab_rd_ok;
  assign ca_ld = fall_through_mode ? (ca_edly[2] && (!ca_out_full || ca_rd_ok))
                                   : ca_rd_ok;

  always_ff @(posedge sys_clk) begin
    if (ab_wr_ok) begin
      ab_mem[ab_wp[PW-1:0]] <= a_s2[QW-1:0];
    end
    if (ca_wr_ok) begin
      ca_mem[ca_wp[PW-1:0]] <= cq_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ab_wp <= '0;
      ab_rp <= '0;
      ca_wp <= '0;
      ca_rp <= '0;
      ab_out <= '0;
      ca_out <= '0;
      ab_out_full <= 1'b0;
      ca_out_full <= 1'b0;
    end else begin
      if (ab_wr_ok) begin
        ab_wp <= ab_wp + 1'b1;
      end
      if (ca_wr_ok) begin
        ca_wp <= ca_wp + 1'b1;
      end
      if (ab_ld) begin
        ab_out <= ab_mem[ab_rp[PW-1:0]];
        ab_rp  <= ab_rp + 1'b1;
        ab_out_full <= 1'b1;
      end else if (ab_rd_ok) begin
        ab_out_full <= 1'b0;
      end
      if (ca_ld) begin
        ca_out <= ca_mem[ca_rp[PW-1:0]];
        ca_rp  <= ca_rp + 1'b1;
        ca_out_full <= 1'b1;
      end else if (ca_rd_ok) begin
        ca_out_full <= 1'b0;
      end
    end
  end

  // Flag pipelines advance on the owning port clock edge only
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ab_fdly <= '0;
      ca_fdly <= '0;
      ab_edly <= '0;
      ca_edly <= '0;
    end else begin
      if (edge_a) begin
        ab_fdly <= {ab_fdly[0] && ab_full_n, ab_full_n};
        ca_edly <= {ca_edly[1] && ca_avail, ca_edly[0] && ca_avail, ca_avail};
      end
      if (edge_b) begin
        ab_edly <= {ab_edly[1] && ab_avail, ab_edly[0] && ab_avail, ab_avail};
      end
      if (edge_c) begin
        ca_fdly <= {ca_fdly[0] && ca_full_n, ca_full_n};
      end
      if (ab_wr_ok && ab_cnt == (PW+1)'(DEPTH_P-1)) begin
        ab_fdly <= '0;
      end
      if (ca_wr_ok && ca_cnt == (PW+1)'(DEPTH_P-1)) begin
        ca_fdly <= '0;
      end
      if (ab_ld && ab_cnt == (PW+1)'(1)) begin
        ab_edly <= '0;
      end
      if (ca_ld && ca_cnt == (PW+1)'(1)) begin
        ca_edly <= '0;
      end
    end
  end

  // Output flags set after two port edges; cleared on any system clock once the raw compare goes false
  logic [PW:0] ab_af_lim;
  logic [PW:0] ca_af_lim;
  assign ab_af_lim = (PW+1)'(DEPTH_P) - (PW+1)'(ab_full_offset);
  assign ca_af_lim = (PW+1)'(DEPTH_P) - (PW+1)'(ca_full_offset);

  logic ab_ae_raw;
  logic ca_ae_raw;
  logic ab_af_raw;
  logic ca_af_raw;
  logic [1:0] ab_ae_d;
  logic [1:0] ca_ae_d;
  logic [1:0] ab_af_d;
  logic [1:0] ca_af_d;
  assign ab_ae_raw = ab_cnt > (PW+1)'(ab_empty_offset);
  assign ca_ae_raw = ca_cnt > (PW+1)'(ca_empty_offset);
  assign ab_af_raw = ab_cnt < ab_af_lim;
  assign ca_af_raw = ca_cnt < ca_af_lim;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ab_ae_d <= '0;
      ca_ae_d <= '0;
      ab_af_d <= 2'h3;
      ca_af_d <= 2'h3;
    end else begin
      if (edge_b) begin
        ab_ae_d <= {ab_ae_d[0] && ab_ae_raw, ab_ae_raw};
      end
      if (edge_a) begin
        ca_ae_d <= {ca_ae_d[0] && ca_ae_raw, ca_ae_raw};
        ab_af_d <= {ab_af_d[0] && ab_af_raw, ab_af_raw};
      end
      if (edge_c) begin
        ca_af_d <= {ca_af_d[0] && ca_af_raw, ca_af_raw};
      end
      if (!ab_ae_raw) begin
        ab_ae_d <= '0;
      end
      if (!ca_ae_raw) begin
        ca_ae_d <= '0;
      end
      if (!ab_af_raw) begin
        ab_af_d <= '0;
      end
      if (!ca_af_raw) begin
        ca_af_d <= '0;
      end
    end
  end

  assign port_a_full_or_in_ready   = ab_fdly[1];
  assign port_c_full_or_in_ready   = ca_fdly[1];
  assign port_b_almost_empty       = ab_ae_d[1];
  assign port_a_almost_empty       = ca_ae_d[1];
  assign port_a_almost_full        = ab_af_d[1];
  assign port_c_almost_full        = ca_af_d[1];
  // Fall-through shows the output word; standard shows memory data
  assign port_b_empty_or_out_ready = fall_through_mode ? ab_out_full
                                                       : ab_edly[1];
  assign port_a_empty_or_out_ready = fall_through_mode ? ca_out_full
                                                       : ca_edly[1];

  // Port C half-word assembly into the buffer
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      c_half <= 1'b0;
      c_hold <= '0;
    end else if (c_wr && !s2[7] && cf_ready) begin
      c_half <= !c_half;
      c_hold <= c_s2;
    end
  end
  assign cf_valid = c_wr && !s2[7] && c_half;
  assign cf_data  = {c_hold, c_s2};

  tqf_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_cbuf (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (cf_valid),
    .in_ready  (cf_ready),
    .in_data   (cf_data),
    .out_valid (cq_valid),
    .out_ready (cq_take),
    .out_data  (cq_data)
  );

  // Mailbox registers, no endian ordering applied
  logic [MW-1:0] port_a_to_b_bypass;
  logic [MW-1:0] port_c_to_a_bypass;
  logic          ab_mail_wr;
  logic          ca_mail_wr;
  logic          ab_mail_rd;
  logic          ca_mail_rd;
  assign ab_mail_wr = a_wr && a_mb && ab_mail_flag;
  assign ca_mail_wr = c_wr && s2[7] && ca_mail_flag;
  assign ab_mail_rd = b_rd && s2[5];
  assign ca_mail_rd = a_rd && a_mb;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      port_a_to_b_bypass <= '0;
      port_c_to_a_bypass <= '0;
    end else begin
      if (ab_mail_wr) begin
        port_a_to_b_bypass <= port_b_byte_size ? {9'h000, a_s2[8:0]}
                                               : a_s2[MW-1:0];
      end
      if (ca_mail_wr) begin
        port_c_to_a_bypass <= port_c_byte_size ? {9'h000, c_s2[8:0]}
                                               : c_s2;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ab_mail_flag <= 1'b1;
      ca_mail_flag <= 1'b1;
    end else begin
      if (ab_mail_wr) begin
        ab_mail_flag <= 1'b0;
      end else if (ab_mail_rd) begin
        ab_mail_flag <= 1'b1;
      end
      if (ca_mail_wr) begin
        ca_mail_flag <= 1'b0;
      end else if (ca_mail_rd) begin
        ca_mail_flag <= 1'b1;
      end
    end
  end

  // Data outputs: mail when select high, queue output register otherwise
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      port_a_data_out  <= '0;
      port_b_data_out  <= '0;
      port_a_data_oe_n <= 1'b1;
      port_b_data_oe_n <= 1'b1;
    end else begin
      port_a_data_oe_n <= !((!a_s2[QW+3]) && !a_s2[QW+2]);
      port_b_data_oe_n <= s2[3];
      port_a_data_out  <= a_mb ? {port_c_to_a_bypass, 18'h00000} : ca_out;
      port_b_data_out  <= s2[5] ? port_a_to_b_bypass : ab_out[MW-1:0];
    end
  end
endmodule

// >>> tb/tqf_core_chk.sv
// Checker of flag and mailbox timing at the block ports
`timescale 1ns/1ns
module tqf_core_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Port controls
  input wire logic port_a_clock,
  input wire logic port_b_clock,
  input wire logic port_c_clock,
  input wire logic port_a_select_n,
  input wire logic port_a_write_not_read,
  input wire logic port_a_enable,
  input wire logic port_a_mail_select,
  input wire logic port_b_select_n,
  input wire logic port_b_read_enable,
  input wire logic port_b_mail_select,
  input wire logic port_c_write_enable,
  input wire logic port_c_mail_select,
  // Flags
  input wire logic port_a_full_or_in_ready,
  input wire logic port_c_full_or_in_ready,
  input wire logic port_a_almost_full,
  input wire logic port_a_almost_empty,
  input wire logic port_a_empty_or_out_ready,
  input wire logic port_b_empty_or_out_ready,
  input wire logic port_b_almost_empty,
  input wire logic ab_mail_flag,
  input wire logic ca_mail_flag,
  // Data enables
  input wire logic port_a_data_oe_n,
  input wire logic port_b_data_oe_n
);
  wire a_mreq = !port_a_select_n && port_a_enable && port_a_mail_select;
  wire b_mreq = !port_b_select_n && port_b_read_enable && port_b_mail_select;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Mail transfers at a port clock edge
  sequence s_a_mwr; $rose(port_a_clock) && a_mreq && port_a_write_not_read; endsequence
  sequence s_a_mrd; $rose(port_a_clock) && a_mreq && !port_a_write_not_read; endsequence
  sequence s_b_mrd; $rose(port_b_clock) && b_mreq; endsequence
  sequence s_c_mwr; $rose(port_c_clock) && port_c_write_enable && port_c_mail_select; endsequence
  property p_ab_low; s_a_mwr |-> ##[2:8] !ab_mail_flag; endproperty
  property p_ab_high; s_b_mrd |-> ##[2:8] ab_mail_flag; endproperty
  property p_ca_low; s_c_mwr |-> ##[2:8] !ca_mail_flag; endproperty
  property p_ca_high; s_a_mrd |-> ##[2:8] ca_mail_flag; endproperty
  property p_rst_mail; $rose(rst_n) |-> ab_mail_flag && ca_mail_flag; endproperty
  property p_rst_flags;
    $rose(rst_n) |-> !port_b_empty_or_out_ready && !port_a_empty_or_out_ready;
  endproperty
  property p_full_af; $fell(port_a_full_or_in_ready) |-> !port_a_almost_full; endproperty
  property p_ae_b; $rose(port_b_almost_empty) |-> port_b_empty_or_out_ready; endproperty
  property p_ae_a; $rose(port_a_almost_empty) |-> port_a_empty_or_out_ready; endproperty
  property p_a_oe;
    !port_a_select_n && !port_a_write_not_read |-> ##3 !port_a_data_oe_n;
  endproperty
  property p_b_oe; !port_b_select_n |-> ##3 !port_b_data_oe_n; endproperty
  property p_oe_idle;
    $rose(rst_n) |-> (port_a_data_oe_n && port_b_data_oe_n)[*2];
  endproperty
  a_ab_low: assert property (p_ab_low) else $error("ab mail flag stayed high");
  a_ab_high: assert property (p_ab_high) else $error("ab mail flag stayed low");
  a_ca_low: assert property (p_ca_low) else $error("ca mail flag stayed high");
  a_ca_high: assert property (p_ca_high) else $error("ca mail flag stayed low");
  a_rst_mail: assert property (p_rst_mail) else $error("mail flag low after reset");
  a_rst_flags: assert property (p_rst_flags) else $error("empty flag high at reset");
  a_full_af: assert property (p_full_af) else $error("full without almost full");
  a_ae_b: assert property (p_ae_b) else $error("port b almost empty while empty");
  a_ae_a: assert property (p_ae_a) else $error("port a almost empty while empty");
  a_a_oe: assert property (p_a_oe) else $error("port a outputs not enabled on read");
  a_b_oe: assert property (p_b_oe) else $error("port b outputs not enabled");
  a_oe_idle: assert property (p_oe_idle) else $error("outputs enabled after reset");
endmodule
bind tqf_core tqf_core_chk chk_u (.*);

// >>> tb/tqf_port_model.sv
// Far-side model: port clocks and control drivers for ports A, B and C
`timescale 1ns/1ns
module tqf_port_model (
  // System clock
  input  wire logic                   sys_clk,
  // Port clocks
  output logic                        port_a_clock,
  output logic                        port_b_clock,
  output logic                        port_c_clock,
  // Port A
  output logic                        port_a_select_n,
  output logic                        port_a_write_not_read,
  output logic                        port_a_enable,
  output logic                        port_a_mail_select,
  output logic [tqf_pkg::QW-1:0]      port_a_data_in,
  // Port B
  output logic                        port_b_select_n,
  output logic                        port_b_read_enable,
  output logic                        port_b_mail_select,
  // Port C
  output logic                        port_c_write_enable,
  output logic                        port_c_mail_select,
  output logic [tqf_pkg::MW-1:0]      port_c_data_in
);
  import tqf_pkg::*;
  initial begin
    {port_a_clock, port_b_clock, port_c_clock} = 3'h0;
    {port_a_select_n, port_b_select_n} = 2'h3;
    {port_a_write_not_read, port_a_enable, port_a_mail_select} = 3'h0;
    {port_b_read_enable, port_b_mail_select, port_c_write_enable} = 3'h0;
    port_c_mail_select = 1'h1;
    port_a_data_in = '0;
    port_c_data_in = '0;
  end
  // Free-running port clocks of unrelated phase
  initial #7 forever #80 port_a_clock = ~port_a_clock;
  initial #33 forever #80 port_b_clock = ~port_b_clock;
  initial #59 forever #80 port_c_clock = ~port_c_clock;
  // Wait for a port clock level change, then one system edge
  task automatic edge_of(input int p, input logic lvl);
    case (p)
      0: @(port_a_clock iff port_a_clock == lvl);
      1: @(port_b_clock iff port_b_clock == lvl);
      default: @(port_c_clock iff port_c_clock == lvl);
    endcase
    @(posedge sys_clk);
  endtask
  task automatic op_a(input logic wr, input logic mb, input logic [QW-1:0] d);
    edge_of(0, 1'h0);
    port_a_select_n <= 1'h0;
    port_a_write_not_read <= wr;
    port_a_enable <= 1'h1;
    port_a_mail_select <= mb;
    port_a_data_in <= d;
    edge_of(0, 1'h1);
    edge_of(0, 1'h0);
    port_a_select_n <= 1'h1;
    port_a_enable <= 1'h0;
    port_a_data_in <= ~d;
  endtask
  task automatic op_b(input logic mb);
    edge_of(1, 1'h0);
    port_b_select_n <= 1'h0;
    port_b_read_enable <= 1'h1;
    port_b_mail_select <= mb;
    edge_of(1, 1'h1);
    edge_of(1, 1'h0);
    port_b_select_n <= 1'h1;
    port_b_read_enable <= 1'h0;
  endtask
  task automatic op_c(input logic mb, input logic [MW-1:0] d);
    edge_of(2, 1'h0);
    port_c_write_enable <= 1'h1;
    port_c_mail_select <= mb;
    port_c_data_in <= d;
    edge_of(2, 1'h1);
    edge_of(2, 1'h0);
    port_c_write_enable <= 1'h0;
    port_c_data_in <= ~d;
  endtask
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the queue flag and mailbox block
`timescale 1ns/1ns
module tb_top;
  import tqf_pkg::*;
  logic                   sys_clk, rst_n, offset_load, fall_through_mode;
  logic                   port_b_byte_size, port_c_byte_size;
  logic [OFS_W-1:0]       ab_empty_offset_in, ab_full_offset_in;
  logic [OFS_W-1:0]       ca_empty_offset_in, ca_full_offset_in;
  logic                   port_a_clock, port_b_clock, port_c_clock;
  logic                   port_a_select_n, port_a_write_not_read, port_a_enable;
  logic                   port_a_mail_select, port_a_data_oe_n, port_a_full_or_in_ready;
  logic                   port_a_empty_or_out_ready, port_a_almost_empty, port_a_almost_full;
  logic [QW-1:0]          port_a_data_in, port_a_data_out;
  logic                   port_b_select_n, port_b_read_enable, port_b_mail_select;
  logic                   port_b_data_oe_n, port_b_empty_or_out_ready, port_b_almost_empty;
  logic [MW-1:0]          port_b_data_out, port_c_data_in;
  logic                   port_c_write_enable, port_c_mail_select;
  logic                   port_c_full_or_in_ready, port_c_almost_full, ab_mail_flag, ca_mail_flag;
  int                     fails, n_compared, xe, yf;
  logic [QW-1:0]          w;
  logic [MW-1:0]          m;
  logic [QW-1:0]          q[$];

  tqf_core dut_u (.*);
  tqf_port_model pm_u (.*);

  function automatic logic ae_exp(input int cnt, input int x);
    return cnt > x;
  endfunction
  function automatic logic af_exp(input int cnt, input int y);
    return cnt < DEPTH - y;
  endfunction
  task automatic chk(input string nm, input logic [QW-1:0] seen, input logic [QW-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results;
    if (fails == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic settle;
    repeat (2) @(negedge sys_clk);
  endtask

  initial begin
    sys_clk = 1'h0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Watchdog well beyond the expected run length
  initial begin
    waitc(40000);
    fails++;
    results();
  end
  initial begin
    void'($urandom(37));
    {rst_n, offset_load, fall_through_mode, port_b_byte_size, port_c_byte_size} = 5'h0;
    {ab_empty_offset_in, ab_full_offset_in, ca_empty_offset_in, ca_full_offset_in} = '0;
    fails = 0;
    n_compared = 0;
    waitc(6);
    rst_n <= 1'h1;
    for (int i = 0; i < 400 && (port_a_full_or_in_ready & port_c_full_or_in_ready) !== 1'h1; i++)
      waitc(1);
    settle();
    chk("full_flags", {port_a_full_or_in_ready, port_c_full_or_in_ready}, 2'h3);
    chk("mail_flags", {ab_mail_flag, ca_mail_flag}, 2'h3);
    xe = 1 + $urandom % 6;
    yf = 2 + $urandom % 6;
    waitc(1);
    ab_empty_offset_in <= OFS_W'(xe);
    ab_full_offset_in <= OFS_W'(yf);
    ca_empty_offset_in <= 10'h001;
    ca_full_offset_in <= OFS_W'(yf);
    offset_load <= 1'h1;
    waitc(1);
    offset_load <= 1'h0;
    // Mailbox A to B, second write refused, read twice
    w = QW'({$urandom, $urandom});
    pm_u.op_a(1'h1, 1'h1, w);
    settle();
    chk("ab_flag", ab_mail_flag, 1'h0);
    pm_u.op_a(1'h1, 1'h1, ~w);
    repeat (2) begin
      pm_u.op_b(1'h1);
      settle();
      chk("b_mail", port_b_data_out, w[MW-1:0]);
      chk("ab_flag", ab_mail_flag, 1'h1);
    end
    // Mailbox C to A
    m = MW'($urandom);
    pm_u.op_c(1'h1, m);
    settle();
    chk("ca_flag", ca_mail_flag, 1'h0);
    pm_u.op_a(1'h0, 1'h1, '0);
    settle();
    chk("a_mail", port_a_data_out[QW-1:MW], m);
    chk("ca_flag", ca_mail_flag, 1'h1);
    // Port C halves pair into long words for port A
    for (int i = 0; i < 4; i++) begin
      m = MW'($urandom);
      w = {w[MW-1:0], m};
      pm_u.op_c(1'h0, m);
      if (i % 2 == 1) q.push_back(w);
    end
    waitc(60);
    chk("a_ready", port_a_empty_or_out_ready, 1'h1);
    chk("a_ae", port_a_almost_empty, ae_exp(2, 1));
    while (q.size() > 0) begin
      w = q.pop_front();
      pm_u.op_a(1'h0, 1'h0, '0);
      settle();
      chk("a_queue", port_a_data_out, w);
    end
    // Fill A to B queue, checking threshold crossings
    for (int i = 1; i <= DEPTH; i++) begin
      w = QW'({$urandom, $urandom});
      q.push_back(w);
      pm_u.op_a(1'h1, 1'h0, w);
      if (i == xe || i == xe + 1 || i == DEPTH - yf - 1 || i == DEPTH - yf) begin
        waitc(40);
        chk("b_ae", port_b_almost_empty, ae_exp(i, xe));
        chk("a_af", port_a_almost_full, af_exp(i, yf));
        chk("b_ready", port_b_empty_or_out_ready, 1'h1);
      end
    end
    waitc(40);
    chk("a_full", port_a_full_or_in_ready, 1'h0);
    pm_u.op_a(1'h1, 1'h0, ~w);
    w = q.pop_front();
    pm_u.op_b(1'h0);
    settle();
    chk("b_queue", port_b_data_out, w[MW-1:0]);
    waitc(32);
    chk("a_full", port_a_full_or_in_ready, 1'h1);
    while (q.size() > 0) begin
      w = q.pop_front();
      pm_u.op_b(1'h0);
      settle();
      chk("b_queue", port_b_data_out, w[MW-1:0]);
    end
    waitc(40);
    chk("b_ready", port_b_empty_or_out_ready, 1'h0);
    chk("a_af", port_a_almost_full, af_exp(0, yf));
    chk("a_ready", port_a_empty_or_out_ready, 1'h0);
    chk("c_af", port_c_almost_full, af_exp(0, yf));
    // Second reset into fall-through timing and byte-wide mail
    rst_n <= 1'h0;
    fall_through_mode <= 1'h1;
    port_b_byte_size <= 1'h1;
    pm_u.op_c(1'h1, '0);
    rst_n <= 1'h1;
    waitc(40);
    chk("mail_flags", {ab_mail_flag, ca_mail_flag}, 2'h3);
    w = QW'({$urandom, $urandom});
    pm_u.op_a(1'h1, 1'h0, w);
    waitc(40);
    chk("b_or", port_b_empty_or_out_ready, 1'h1);
    chk("b_fall_through_mode", port_b_data_out, w[MW-1:0]);
    pm_u.op_b(1'h0);
    settle();
    chk("b_or", port_b_empty_or_out_ready, 1'h0);
    w = ~w;
    pm_u.op_a(1'h1, 1'h1, w);
    pm_u.op_b(1'h1);
    settle();
    chk("b_mail9", port_b_data_out[8:0], w[8:0]);
    results();
  end
endmodule
